// >>> design/rmfr_pkg.sv
// package: constants and types of the rail monitor fault reaction block
`default_nettype none
package rmfr_pkg;
  // ===========================================================
  // timing
  localparam int CLK_NS      = 40;
  localparam int EXT_DG_NS   = 21000;
  localparam int BST_DG_NS   = 21000;
  localparam int INTERNAL_REGULATOR_RAIL_UV_NS  = 24000;
  localparam int INTERNAL_REGULATOR_RAIL_OV_NS  = 10000;
  localparam int VIO_OV_NS   = 10000;
  localparam int PROT_OFF_NS = 200000;
  localparam int EXT_DG_CYC  = (EXT_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int BST_DG_CYC  = (BST_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int VUV_DG_CYC  = (INTERNAL_REGULATOR_RAIL_UV_NS + CLK_NS - 1) / CLK_NS;
  localparam int VOV_DG_CYC  = (INTERNAL_REGULATOR_RAIL_OV_NS + CLK_NS - 1) / CLK_NS;
  localparam int VIO_DG_CYC  = (VIO_OV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_OFF_CYC = PROT_OFF_NS / CLK_NS;
  // ===========================================================
  // register offsets (byte addresses)
  localparam logic [5:0] OFS_UV_FLAGS  = 6'h00;
  localparam logic [5:0] OFS_OV_FLAGS  = 6'h04;
  localparam logic [5:0] OFS_SAFE_FLAGS = 6'h08;
  localparam logic [5:0] OFS_EXT_FLAGS = 6'h0c;
  localparam logic [5:0] OFS_ENABLES   = 6'h10;
  localparam logic [5:0] OFS_CONTROL   = 6'h14;
  localparam logic [5:0] OFS_STATE     = 6'h18;
  localparam logic [5:0] OFS_MASK0     = 6'h20;
  // ===========================================================
  // field positions
  localparam int UV_BOOST_BIT = 3;
  localparam int UV_INTERNAL_REGULATOR_RAIL_BIT  = 4;
  localparam int UV_BATT_BIT  = 6;
  localparam int OV_BOOST_BIT = 3;
  localparam int OV_INTERNAL_REGULATOR_RAIL_BIT  = 4;
  localparam int OV_VIO_BIT   = 7;
  localparam int SF_OVP_BIT   = 3;
  localparam int EXT_UV_LSB   = 0;
  localparam int EXT_OV_LSB   = 4;
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam logic [10:0] ENABLE_RST = 11'h000;
  // ===========================================================
  // types
  typedef enum logic [1:0] {
    RMFR_ACTIVE = 2'b00,
    RMFR_SAFE   = 2'b01,
    RMFR_RESET  = 2'b10,
    RMFR_OFF    = 2'b11
  } rmfr_state_e;
  typedef struct packed {
    logic       boost_uv;
    logic       boost_ov;
    logic       boost_ovp;
    logic [1:0] ext_uv;
    logic [1:0] ext_ov;
    logic       internal_regulator_rail_uv;
    logic       internal_regulator_rail_ov;
    logic       vio_ov;
  } rmfr_cmp_s;
  typedef struct packed {
    logic o;
    logic oe;
  } rmfr_pin_s;
endpackage
`default_nettype wire

// >>> design/rmfr_top.sv
// module: deglitch, status flags, power state reaction and register slave
`default_nettype none
// Functional notes
// - boost UV sets flag 3, RESET if enabled
// - boost UV pins low if enabled, else untouched
// - boost OV flag 3, RESET or SAFE
// - boost OVERVOLTAGE_PROTECTION flag 3, SAFE, reset high
// - lasting boost OVERVOLTAGE_PROTECTION after disable gives OFF
// - lasting second buck OVERVOLTAGE_PROTECTION gives OFF
// - first buck extended overprotection gives OFF
// - external UV flags [1:0], RESET if reset enabled, else SAFE if irq enabled, else no state change
// - external OV flags [5:4], RESET if reset enabled, else SAFE if irq enabled, else no state change
// - internal rail UV/OV flag 4, OFF
// - internal rail deglitch 24us UV, 10us OV
// - IO supply OV flag 7, no state change
// - battery low irq enable pulls driver low
// - IO supply lost: drive low only
module rmfr_top #(
  parameter int PROT_OFF_CYC = rmfr_pkg::PROT_OFF_CYC
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire rmfr_pkg::rmfr_cmp_s cmp,
  input  wire logic              buck2_ovp,
  input  wire logic              buck1_extended_overprotection,
  input  wire logic              battery_uv,
  output logic                   step_up_disable,
  output logic                   second_buck_disable,
  output rmfr_pkg::rmfr_pin_s    host_reset_out,
  output rmfr_pkg::rmfr_pin_s    driver_enable_irq_out,
  output logic                   irq,
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);
  localparam int NCH = 10;
  // ===========================================================
  // deglitch filters
  function automatic logic [9:0] dg_len(input int ch);
    case (ch)
      0, 1, 2: dg_len = 10'(rmfr_pkg::BST_DG_CYC);
      7:       dg_len = 10'(rmfr_pkg::VUV_DG_CYC);
      8:       dg_len = 10'(rmfr_pkg::VOV_DG_CYC);
      9:       dg_len = 10'(rmfr_pkg::VIO_DG_CYC);
      default: dg_len = 10'(rmfr_pkg::EXT_DG_CYC);
    endcase
  endfunction
  logic [NCH-1:0] raw;
  logic [NCH-1:0] flt_r;
  logic [NCH-1:0] ev;
  assign raw = {cmp.vio_ov, cmp.internal_regulator_rail_ov, cmp.internal_regulator_rail_uv, cmp.ext_ov, cmp.ext_uv,
                cmp.boost_ovp, cmp.boost_ov, cmp.boost_uv};
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_dg
      logic [9:0] cnt_r;
      always_ff @(posedge clk) begin
        if (srst || !raw[i]) begin
          cnt_r <= 10'h000;
          flt_r[i] <= 1'b0;
        end else if (cnt_r == dg_len(i) - 10'h001) begin
          flt_r[i] <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 10'h001;
        end
      end
      assign ev[i] = raw[i] && !flt_r[i] && (cnt_r == dg_len(i) - 10'h001);
    end
  endgenerate
  // ===========================================================
  // configuration and edge capture
  logic [10:0] en_r;
  logic        step_up_uv_reset_enable, step_up_ov_reset_enable, battery_low_irq_enable;
  logic [1:0]  ext_sense_uv_reset_enable, ext_sense_uv_irq_enable;
  logic [1:0]  ext_sense_ov_reset_enable, ext_sense_ov_irq_enable;
  assign step_up_uv_reset_enable   = en_r[0];
  assign step_up_ov_reset_enable   = en_r[1];
  assign ext_sense_uv_reset_enable = en_r[3:2];
  assign ext_sense_uv_irq_enable   = en_r[5:4];
  assign ext_sense_ov_reset_enable = en_r[7:6];
  assign ext_sense_ov_irq_enable   = en_r[9:8];
  assign battery_low_irq_enable    = en_r[10];
  logic b2_d_r, extended_overprotection_d_r, batt_d_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      b2_d_r <= 1'b0;
      extended_overprotection_d_r <= 1'b0;
      batt_d_r <= 1'b0;
    end else begin
      b2_d_r <= buck2_ovp;
      extended_overprotection_d_r <= buck1_extended_overprotection;
      batt_d_r <= battery_uv;
    end
  end
  logic b2_ev, extended_overprotection_ev, batt_ev;
  assign b2_ev   = buck2_ovp && !b2_d_r;
  assign extended_overprotection_ev = buck1_extended_overprotection && !extended_overprotection_d_r;
  assign batt_ev = battery_uv && !batt_d_r;
  // ===========================================================
  // bus access strobes
  logic ack_r;
  logic wr_ack;
  logic [31:0] wmask;
  logic [3:0]  widx;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_ack = avs_write && ack_r;
  assign widx = avs_address[5:2];
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // ===========================================================
  // sticky flags, set wins over write-one-to-clear
  logic [7:0] set_v [4];
  logic [7:0] flags_r [4];
  logic [7:0] mask_r [4];
  always_comb begin
    for (int k = 0; k < 4; k++) set_v[k] = 8'h00;
    set_v[0][rmfr_pkg::UV_BOOST_BIT] = ev[0];
    set_v[0][rmfr_pkg::UV_INTERNAL_REGULATOR_RAIL_BIT]  = ev[7];
    set_v[0][rmfr_pkg::UV_BATT_BIT]  = batt_ev;
    set_v[1][rmfr_pkg::OV_BOOST_BIT] = ev[1];
    set_v[1][rmfr_pkg::OV_INTERNAL_REGULATOR_RAIL_BIT]  = ev[8];
    set_v[1][rmfr_pkg::OV_VIO_BIT]   = ev[9];
    set_v[2][rmfr_pkg::SF_OVP_BIT]   = ev[2];
    set_v[3][rmfr_pkg::EXT_UV_LSB +: 2] = ev[4:3];
    set_v[3][rmfr_pkg::EXT_OV_LSB +: 2] = ev[6:5];
  end
  generate
    for (genvar r = 0; r < 4; r++) begin : g_flag
      always_ff @(posedge clk) begin
        if (srst) begin
          flags_r[r] <= rmfr_pkg::FLAGS_RST;
          mask_r[r] <= rmfr_pkg::FLAGS_RST;
        end else begin
          if (wr_ack && widx == 4'(r))
            flags_r[r] <= (flags_r[r] & ~(avs_writedata[7:0] & wmask[7:0])) | set_v[r];
          else
            flags_r[r] <= flags_r[r] | set_v[r];
          if (wr_ack && widx == 4'(r) + (rmfr_pkg::OFS_MASK0[5:2]))
            mask_r[r] <= (mask_r[r] & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |((flags_r[0] & mask_r[0]) | (flags_r[1] & mask_r[1]) |
               (flags_r[2] & mask_r[2]) | (flags_r[3] & mask_r[3]));
  end
  // ===========================================================
  // protection-off timers
  logic [15:0] bst_off_cnt_r, b2_off_cnt_r;
  logic        bst_off_done, b2_off_done;
  logic        resume;
  assign resume = wr_ack && avs_address[5:2] == rmfr_pkg::OFS_CONTROL[5:2]
                  && avs_byteenable[0] && avs_writedata[0];
  always_ff @(posedge clk) begin
    if (srst) begin
      step_up_disable <= 1'b0;
      second_buck_disable <= 1'b0;
    end else begin
      if (ev[2])
        step_up_disable <= 1'b1;
      else if (resume)
        step_up_disable <= 1'b0;
      if (b2_ev)
        second_buck_disable <= 1'b1;
      else if (resume)
        second_buck_disable <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || !(step_up_disable && flt_r[2]))
      bst_off_cnt_r <= 16'h0000;
    else if (!bst_off_done)
      bst_off_cnt_r <= bst_off_cnt_r + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (srst || !(second_buck_disable && buck2_ovp))
      b2_off_cnt_r <= 16'h0000;
    else if (!b2_off_done)
      b2_off_cnt_r <= b2_off_cnt_r + 16'h0001;
  end
  assign bst_off_done = bst_off_cnt_r == 16'(PROT_OFF_CYC);
  assign b2_off_done  = b2_off_cnt_r == 16'(PROT_OFF_CYC);
  // ===========================================================
  // power state reaction
  rmfr_pkg::rmfr_state_e state_r, state_nxt;
  logic off_ev, reset_ev, safe_ev;
  assign off_ev = ev[7] || ev[8] || extended_overprotection_ev || bst_off_done || b2_off_done;
  assign reset_ev = (ev[0] && step_up_uv_reset_enable)
                 || (ev[1] && step_up_ov_reset_enable)
                 || |(ev[4:3] & ext_sense_uv_reset_enable)
                 || |(ev[6:5] & ext_sense_ov_reset_enable);
  assign safe_ev = (ev[1] && !step_up_ov_reset_enable) || ev[2] || b2_ev
                 || |(ev[4:3] & ~ext_sense_uv_reset_enable & ext_sense_uv_irq_enable)
                 || |(ev[6:5] & ~ext_sense_ov_reset_enable & ext_sense_ov_irq_enable);
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rmfr_pkg::RMFR_OFF: state_nxt = rmfr_pkg::RMFR_OFF;
      default: begin
        if (off_ev)
          state_nxt = rmfr_pkg::RMFR_OFF;
        else if (reset_ev)
          state_nxt = rmfr_pkg::RMFR_RESET;
        else if (safe_ev && state_r != rmfr_pkg::RMFR_RESET)
          state_nxt = rmfr_pkg::RMFR_SAFE;
        else if (resume)
          state_nxt = rmfr_pkg::RMFR_ACTIVE;
      end
    endcase
  end
  logic host_reset_out_r, drv_r, vio_lost;
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= rmfr_pkg::RMFR_ACTIVE;
      host_reset_out_r <= 1'b0;
      drv_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      host_reset_out_r <= state_nxt == rmfr_pkg::RMFR_ACTIVE || state_nxt == rmfr_pkg::RMFR_SAFE;
      drv_r <= state_nxt == rmfr_pkg::RMFR_ACTIVE
               && !(battery_low_irq_enable && (flags_r[0][rmfr_pkg::UV_BATT_BIT]
               || batt_ev));
    end
  end
  assign vio_lost = flt_r[9];
  assign host_reset_out.o = host_reset_out_r;
  assign host_reset_out.oe = !vio_lost || !host_reset_out_r;
  assign driver_enable_irq_out.o = drv_r;
  assign driver_enable_irq_out.oe = !vio_lost || !drv_r;
  // ===========================================================
  // register read and answer
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      en_r <= rmfr_pkg::ENABLE_RST;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (wr_ack && widx == rmfr_pkg::OFS_ENABLES[5:2])
        en_r <= (en_r & ~wmask[10:0]) | (avs_writedata[10:0] & wmask[10:0]);
      if (avs_read && !ack_r) begin
        case (widx)
          4'h0, 4'h1, 4'h2, 4'h3: avs_readdata <= {24'h000000, flags_r[widx[1:0]]};
          4'h4: avs_readdata <= {21'h000000, en_r};
          4'h6: avs_readdata <= {28'h0000000, vio_lost, drv_r, state_r};
          4'h8, 4'h9, 4'ha, 4'hb: avs_readdata <= {24'h000000, mask_r[widx[1:0]]};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ===========================================================
  // checks
  sequence s_boost_uv_rst;
    ev[0] && step_up_uv_reset_enable && !off_ev && state_r != rmfr_pkg::RMFR_OFF;
  endsequence
  sequence s_quiet_boost_uv;
    ev[0] && !step_up_uv_reset_enable && !off_ev && !reset_ev && !safe_ev && !resume;
  endsequence
  a_boost_uv_flag: assert property (@(posedge clk) disable iff (srst)
    ev[0] |=> flags_r[0][rmfr_pkg::UV_BOOST_BIT])
    else $error("boost undervoltage flag not set");
  a_boost_uv_reset: assert property (@(posedge clk) disable iff (srst)
    s_boost_uv_rst |=> state_r == rmfr_pkg::RMFR_RESET && !host_reset_out_r && !drv_r)
    else $error("boost undervoltage did not give reset");
  a_boost_uv_hold: assert property (@(posedge clk) disable iff (srst)
    s_quiet_boost_uv |=> $stable(state_r) && $stable(host_reset_out_r))
    else $error("boost undervoltage changed state while disabled");
  a_ovp_safe_pins: assert property (@(posedge clk) disable iff (srst)
    ev[2] && !off_ev && !reset_ev && state_r == rmfr_pkg::RMFR_ACTIVE
    |=> state_r == rmfr_pkg::RMFR_SAFE && host_reset_out_r && !drv_r && step_up_disable)
    else $error("boost overprotection did not give safe");
  a_internal_regulator_rail_off: assert property (@(posedge clk) disable iff (srst)
    (ev[7] || ev[8]) |=> state_r == rmfr_pkg::RMFR_OFF ##1 state_r == rmfr_pkg::RMFR_OFF)
    else $error("internal rail fault did not give off");
  a_ext_deglitch: assert property (@(posedge clk) disable iff (srst)
    $rose(flt_r[3]) |-> $past(raw[3], 1) && $past(raw[3], 8) && $past(raw[3], 300))
    else $error("external undervoltage flagged too early");
  a_glitch_restart: assert property (@(posedge clk) disable iff (srst)
    !raw[7] |=> !flt_r[7] [*2])
    else $error("deglitch did not restart");
  a_vio_no_pullup: assert property (@(posedge clk) disable iff (srst)
    vio_lost |-> !(host_reset_out.oe && host_reset_out.o)
                 && !(driver_enable_irq_out.oe && driver_enable_irq_out.o))
    else $error("pin driven high without supply");
  a_extended_overprotection_off: assert property (@(posedge clk) disable iff (srst)
    extended_overprotection_ev |=> state_r == rmfr_pkg::RMFR_OFF)
    else $error("extended overprotection did not give off");
  a_bus_answer: assert property (@(posedge clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  sequence s_act_calm;
    !off_ev && !reset_ev && state_r == rmfr_pkg::RMFR_ACTIVE;
  endsequence
  a_boost_ov_flag: assert property (@(posedge clk) disable iff (srst)
    ev[1] |=> flags_r[1][rmfr_pkg::OV_BOOST_BIT])
    else $error("boost overvoltage flag not set");
  a_boost_ov_safe: assert property (@(posedge clk) disable iff (srst)
    (ev[1] && !step_up_ov_reset_enable) ##0 s_act_calm
    |=> state_r == rmfr_pkg::RMFR_SAFE && host_reset_out_r && !drv_r)
    else $error("boost overvoltage did not give safe");
  a_ovp_flag: assert property (@(posedge clk) disable iff (srst)
    ev[2] |=> flags_r[2][rmfr_pkg::SF_OVP_BIT])
    else $error("boost overprotection flag not set");
  a_ext_uv_flag: assert property (@(posedge clk) disable iff (srst)
    |ev[4:3] |=> (flags_r[3][rmfr_pkg::EXT_UV_LSB +: 2] & $past(ev[4:3])) == $past(ev[4:3]))
    else $error("external undervoltage flag not set");
  a_ext_ov_flag: assert property (@(posedge clk) disable iff (srst)
    |ev[6:5] |=> (flags_r[3][rmfr_pkg::EXT_OV_LSB +: 2] & $past(ev[6:5])) == $past(ev[6:5]))
    else $error("external overvoltage flag not set");
  a_reset_pins_low: assert property (@(posedge clk) disable iff (srst)
    reset_ev && !off_ev && state_r != rmfr_pkg::RMFR_OFF
    |=> state_r == rmfr_pkg::RMFR_RESET && !host_reset_out_r && !drv_r)
    else $error("reset event did not give reset");
  a_ext_safe_pins: assert property (@(posedge clk) disable iff (srst)
    (|(ev[4:3] & ~ext_sense_uv_reset_enable & ext_sense_uv_irq_enable)
     || |(ev[6:5] & ~ext_sense_ov_reset_enable & ext_sense_ov_irq_enable)) ##0 s_act_calm
    |=> state_r == rmfr_pkg::RMFR_SAFE && host_reset_out_r && !drv_r)
    else $error("external event did not give safe");
  a_internal_regulator_rail_flags: assert property (@(posedge clk) disable iff (srst)
    (ev[7] || ev[8]) |=> (!$past(ev[7]) || flags_r[0][rmfr_pkg::UV_INTERNAL_REGULATOR_RAIL_BIT])
                         && (!$past(ev[8]) || flags_r[1][rmfr_pkg::OV_INTERNAL_REGULATOR_RAIL_BIT]))
    else $error("internal rail flag not set");
  a_off_pins_low: assert property (@(posedge clk) disable iff (srst)
    state_r == rmfr_pkg::RMFR_OFF |-> !host_reset_out_r && !drv_r)
    else $error("pin high in off state");
  a_vio_flag_hold: assert property (@(posedge clk) disable iff (srst)
    ev[9] && !off_ev && !reset_ev && !safe_ev && !resume
    |=> flags_r[1][rmfr_pkg::OV_VIO_BIT] && $stable(state_r))
    else $error("io supply overvoltage flag or state wrong");
  a_boost_off_time: assert property (@(posedge clk) disable iff (srst)
    bst_off_done |=> state_r == rmfr_pkg::RMFR_OFF)
    else $error("lasting boost overprotection did not give off");
  a_buck2_off_time: assert property (@(posedge clk) disable iff (srst)
    b2_off_done |=> state_r == rmfr_pkg::RMFR_OFF)
    else $error("lasting second buck overprotection did not give off");
  a_batt_drv_low: assert property (@(posedge clk) disable iff (srst)
    batt_ev && battery_low_irq_enable |=> !drv_r)
    else $error("battery low did not pull driver low");
  a_internal_regulator_rail_deglitch: assert property (@(posedge clk) disable iff (srst)
    $rose(flt_r[7]) |-> $past(raw[7], 1) && $past(raw[7], 300))
    else $error("internal undervoltage flagged too early");
  a_vio_deglitch: assert property (@(posedge clk) disable iff (srst)
    $rose(flt_r[9]) |-> $past(raw[9], 1) && $past(raw[9], 200))
    else $error("io supply overvoltage flagged too early");
endmodule
`default_nettype wire

// >>> test/rmfr_host_model.sv
// host controller model: pin levels seen through its pull-downs
`default_nettype none
module rmfr_host_model (
  input  wire rmfr_pkg::rmfr_pin_s rst_pin,
  input  wire rmfr_pkg::rmfr_pin_s drv_pin,
  output logic                     rst_level,
  output logic                     drv_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // =========================================================
  // released pins fall to the pull-down level
  assign rst_level = rst_pin.oe ? rst_pin.o : 1'b0;
  assign drv_level = drv_pin.oe ? drv_pin.o : 1'b0;
endmodule
`default_nettype wire

// >>> test/tb_rail_monitor_fault_reaction.sv
// testbench: monitor events, reactions, flags, irq and register bus
`default_nettype none
module tb_rail_monitor_fault_reaction;
  timeunit 1ns;
  timeprecision 1ns;
  // =========================================================
  // signals
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  rmfr_pkg::rmfr_cmp_s cmp = '0;
  logic                buck2_ovp = 1'b0;
  logic                buck1_extended_overprotection = 1'b0;
  logic                battery_uv = 1'b0;
  logic                step_up_disable;
  logic                second_buck_disable;
  rmfr_pkg::rmfr_pin_s host_reset_out;
  rmfr_pkg::rmfr_pin_s driver_enable_irq_out;
  logic                irq;
  logic [5:0]          avs_address = '0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = '0;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                rst_lvl;
  logic                drv_lvl;
  int                  err_total = 0;
  int                  checks = 0;
  // event table: comparator, enables, flag register, flag, state, pins, hold
  logic [9:0]  t_cmp [11] = '{10'h200, 10'h200, 10'h100, 10'h100, 10'h020, 10'h040,
                              10'h008, 10'h010, 10'h004, 10'h002, 10'h001};
  logic [10:0] t_en  [11] = '{11'h000, 11'h001, 11'h000, 11'h002, 11'h004, 11'h020,
                              11'h040, 11'h200, 11'h000, 11'h000, 11'h000};
  logic [5:0]  t_ofs [11] = '{6'h00, 6'h00, 6'h04, 6'h04, 6'h0c, 6'h0c,
                              6'h0c, 6'h0c, 6'h00, 6'h04, 6'h04};
  logic [7:0]  t_flg [11] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h01, 8'h02,
                              8'h10, 8'h20, 8'h10, 8'h10, 8'h80};
  logic [1:0]  t_st  [11] = '{2'b00, 2'b10, 2'b01, 2'b10, 2'b10, 2'b01,
                              2'b10, 2'b01, 2'b11, 2'b11, 2'b00};
  logic [1:0]  t_pin [11] = '{2'b11, 2'b00, 2'b10, 2'b00, 2'b00, 2'b10,
                              2'b00, 2'b10, 2'b00, 2'b00, 2'b11};
  int          t_n   [11] = '{530, 530, 530, 530, 530, 530, 530, 530, 610, 260, 260};

  always #20 clk = ~clk;

  rmfr_top #(
    .PROT_OFF_CYC(20)
  ) i_dut (
    .clk                   (clk),
    .srst                  (srst),
    .cmp                   (cmp),
    .buck2_ovp             (buck2_ovp),
    .buck1_extended_overprotection            (buck1_extended_overprotection),
    .battery_uv            (battery_uv),
    .step_up_disable       (step_up_disable),
    .second_buck_disable   (second_buck_disable),
    .host_reset_out        (host_reset_out),
    .driver_enable_irq_out (driver_enable_irq_out),
    .irq                   (irq),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (4'hf),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest)
  );

  rmfr_host_model i_host (
    .rst_pin   (host_reset_out),
    .drv_pin   (driver_enable_irq_out),
    .rst_level (rst_lvl),
    .drv_level (drv_lvl)
  );

  // =========================================================
  // tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (k >= 50) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string what);
    logic [31:0] d;
    bus(1'b0, a, '0, d);
    chk(what, d & m, e);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic fault(input logic [9:0] c, input int n);
    cmp <= c;
    repeat (n) @(posedge clk);
    cmp <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pins(input logic r, input logic d);
    @(negedge clk);
    chk("reset pin", host_reset_out.o, r);
    chk("driver pin", driver_enable_irq_out.o, d);
    @(posedge clk);
  endtask

  // =========================================================
  // tests
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    do_reset();
    pins(1'b1, 1'b1);
    rdchk(rmfr_pkg::OFS_STATE, 32'h3, 32'h0, "state");
    rdchk(6'h3c, '1, 32'h0, "unmapped");
    wr(6'h3c, '1);
    rdchk(rmfr_pkg::OFS_CONTROL, '1, 32'h0, "control");
    fault(10'h200, 300);
    fault(10'h200, 300);
    rdchk(rmfr_pkg::OFS_UV_FLAGS, 32'hff, 32'h0, "uv flags");
    fault(10'h040, 520);
    rdchk(rmfr_pkg::OFS_EXT_FLAGS, 32'hff, 32'h0, "ext flags");
    fault(10'h004, 590);
    rdchk(rmfr_pkg::OFS_UV_FLAGS, 32'hff, 32'h0, "uv flags");
    fault(10'h001, 240);
    rdchk(rmfr_pkg::OFS_OV_FLAGS, 32'hff, 32'h0, "ov flags");
    $display("test short events done");
    for (int i = 0; i < 11; i++) begin
      do_reset();
      wr(rmfr_pkg::OFS_ENABLES, 32'(t_en[i]));
      fault(t_cmp[i], t_n[i]);
      rdchk(t_ofs[i], 32'hff, 32'(t_flg[i]), "flags");
      rdchk(rmfr_pkg::OFS_STATE, 32'h3, 32'(t_st[i]), "state");
      pins(t_pin[i][1], t_pin[i][0]);
      if (i == 0) begin
        wr(rmfr_pkg::OFS_MASK0, 32'h08);
        @(negedge clk);
        chk("irq", irq, 1'b1);
        @(posedge clk);
        wr(rmfr_pkg::OFS_UV_FLAGS, 32'h08);
        rdchk(rmfr_pkg::OFS_UV_FLAGS, 32'hff, 32'h0, "uv flags");
        chk("irq", irq, 1'b0);
      end
      if (i == 2) begin
        wr(rmfr_pkg::OFS_CONTROL, 32'h1);
        rdchk(rmfr_pkg::OFS_STATE, 32'h3, 32'h0, "state");
      end
      if (i == 10) begin
        cmp <= t_cmp[i];
        repeat (t_n[i]) @(posedge clk);
        @(negedge clk);
        chk("reset enable", host_reset_out.oe, 1'b0);
        chk("driver enable", driver_enable_irq_out.oe, 1'b0);
        chk("host reset level", rst_lvl, 1'b0);
        chk("driver level", drv_lvl, 1'b0);
        @(posedge clk);
        cmp <= '0;
      end
      $display("test event %0d done", i);
    end
    do_reset();
    cmp <= 10'h080;
    repeat (528) @(posedge clk);
    pins(1'b1, 1'b0);
    chk("step-up disable", step_up_disable, 1'b1);
    rdchk(rmfr_pkg::OFS_SAFE_FLAGS, 32'hff, 32'h08, "safety flags");
    repeat (40) @(posedge clk);
    rdchk(rmfr_pkg::OFS_STATE, 32'h3, 32'h3, "state");
    cmp <= '0;
    do_reset();
    buck2_ovp <= 1'b1;
    repeat (40) @(posedge clk);
    chk("second buck disable", second_buck_disable, 1'b1);
    buck2_ovp <= 1'b0;
    rdchk(rmfr_pkg::OFS_STATE, 32'h3, 32'h3, "state");
    do_reset();
    buck1_extended_overprotection <= 1'b1;
    repeat (3) @(posedge clk);
    buck1_extended_overprotection <= 1'b0;
    rdchk(rmfr_pkg::OFS_STATE, 32'h3, 32'h3, "state");
    $display("test protection done");
    for (int j = 0; j < 2; j++) begin
      do_reset();
      wr(rmfr_pkg::OFS_ENABLES, j ? 32'h400 : 32'h0);
      battery_uv <= 1'b1;
      repeat (4) @(posedge clk);
      pins(1'b1, j == 0);
      battery_uv <= 1'b0;
    end
    $display("test battery done");
    close_out();
  end
endmodule
`default_nettype wire
